//--- src/etc_pkg.sv
package etc_pkg;

  // core clock and the microsecond tick derived from it
  localparam int unsigned CORE_CLK_HZ = 10_000_000;
  localparam int unsigned TICK_PERIOD_US = 1;
  localparam int unsigned TICK_CYCLES =
    (CORE_CLK_HZ / 1_000_000) * TICK_PERIOD_US;
  localparam int PRESC_W = 4;
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);
  localparam logic [PRESC_W-1:0] PRESC_RESET = 4'h0;

  localparam int VAL_W = 32;
  localparam logic [VAL_W-1:0] VAL_ZERO = 32'h0000_0000;
  localparam logic [VAL_W-1:0] VAL_ONE = 32'h0000_0001;
  localparam int NUM_SRC = 13;
  localparam int NUM_PINS = 3;

  // launch / clear / count source codes; the code is the index into
  // the source vector built inside the block
  typedef enum logic [3:0] {
    SRC_OFF             = 4'h0,
    SRC_CAPTURE_BEGIN   = 4'h1,
    SRC_CAPTURE_FINISH  = 4'h2,
    SRC_INTEG_BEGIN     = 4'h3,
    SRC_INTEG_FINISH    = 4'h4,
    SRC_IMAGE_BEGIN     = 4'h5,
    SRC_ACCEPTED_FRAME  = 4'h6,
    SRC_REJECTED        = 4'h7,
    SRC_INPUT_PIN_A     = 4'h8,
    SRC_INPUT_PIN_B     = 4'h9,
    SRC_INPUT_PIN_C     = 4'ha,
    SRC_FIRST_TIMER     = 4'hb,
    SRC_FIRST_COUNTER   = 4'hc
  } etc_src_t;

  typedef enum logic [1:0] {
    EDGE_UP     = 2'h0,
    EDGE_DOWN   = 2'h1,
    EDGE_EITHER = 2'h2
  } etc_edge_t;

  typedef enum logic [2:0] {
    TMR_IDLE      = 3'h0,
    TMR_TRIG_WAIT = 3'h1,
    TMR_DELAYING  = 3'h2,
    TMR_ACTIVE    = 3'h3,
    TMR_COMPLETED = 3'h4
  } etc_tmr_state_t;

  // one-cycle camera events, all on core_clk
  typedef struct packed {
    logic capture_begin_event;
    logic capture_finish_event;
    logic integration_begin_event;
    logic integration_finish_event;
    logic image_begin_event;
    logic accepted_frame_trigger;
    logic rejected_trigger;
  } etc_events_t;

  typedef struct packed {
    etc_src_t timer_trigger_select;
    etc_edge_t timer_edge_select;
    logic [VAL_W-1:0] pulse_delay_us;
    logic [VAL_W-1:0] pulse_length_us;
  } etc_timer_cfg_t;

  localparam etc_timer_cfg_t TIMER_CFG_RESET = '{
    timer_trigger_select: SRC_OFF,
    timer_edge_select: EDGE_UP,
    pulse_delay_us: 32'h0000_0000,
    pulse_length_us: 32'h0000_0000
  };

  typedef struct packed {
    logic [NUM_PINS-1:0] pinSync1;
    logic [NUM_PINS-1:0] pinSync2;
    logic [NUM_SRC-1:0] prevSig;
    logic [PRESC_W-1:0] presc;
    etc_timer_cfg_t tcfg;
    etc_tmr_state_t tmrState;
    logic [VAL_W-1:0] delayCnt;
    logic [VAL_W-1:0] elapsed;
    logic timerPulse;
    logic timerDone;
    logic countEnPrev;
    logic counting;
    logic [VAL_W-1:0] count;
    logic counterDone;
  } etc_state_t;

  localparam etc_state_t STATE_RESET = '{
    pinSync1: 3'h0,
    pinSync2: 3'h0,
    prevSig: 13'h0000,
    presc: PRESC_RESET,
    tcfg: TIMER_CFG_RESET,
    tmrState: TMR_IDLE,
    delayCnt: VAL_ZERO,
    elapsed: VAL_ZERO,
    timerPulse: 1'b0,
    timerDone: 1'b0,
    countEnPrev: 1'b0,
    counting: 1'b0,
    count: VAL_ZERO,
    counterDone: 1'b0
  };

endpackage

//--- src/etc_timer_counter.sv
// Overview of operation
// - with a selection set, timer launches only from the source it picks
// - with selection off, the timer clear command launches the timer
// - capture, integration, image, accepted and rejected events can launch
// - each of three input pins can launch the timer on a transition
// - first timer end or first counter end can launch, for chaining
// - signal sources are detected on rising, falling or either edge
// - output pulse lasts the programmed whole number of microseconds (one for zero); a timer clear command mid-pulse restarts the count
// - elapsed value reports the running count in microseconds
// - timer clear command sets the elapsed count to zero while the timer is enabled
// - with counter launch off, the counter clear command starts counting
// - command-started: further clear command zeroes and restarts at once
// - command-started: event or limit clear zeroes and halts till command
// - limit-launched counter starts as soon as its mode goes active
// - limit-launched: clear command zeroes, counting goes on
// - limit-launched at the limit: end event, count zeroed, counting continues
// - timer reports idle, waiting, delaying, active or completed
// - timer is disabled or active; configuration taken only while disabled
`timescale 1ns/1ps
module etc_timer_counter import etc_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // camera events and input pins
  input wire etc_events_t events,
  input wire logic [NUM_PINS-1:0] input_pins,
  // timer control
  input wire logic timer_enable_mode,
  input wire etc_timer_cfg_t timer_cfg,
  input wire logic timer_clear_cmd,
  // counter control
  input wire logic count_enable_mode,
  input wire etc_src_t count_launch_select,
  input wire etc_src_t count_clear_select,
  input wire etc_src_t count_event_select,
  input wire etc_edge_t count_edge_select,
  input wire logic [VAL_W-1:0] count_limit,
  input wire logic count_clear_cmd,
  // timer status and output
  output logic timer_pulse,
  output logic first_timer_done,
  output logic [VAL_W-1:0] elapsed_us,
  output etc_tmr_state_t timer_state_report,
  // counter status
  output logic count_limit_reached,
  output logic count_running,
  output logic [VAL_W-1:0] current_count
);

  etc_state_t st;
  etc_state_t next_st;
  logic [NUM_SRC-1:0] sig;
  logic tick;
  logic timerLaunch;
  logic cntHit;
  logic clrHit;
  logic cntLaunchHit;
  logic [VAL_W-1:0] countInc;

  // edge of the selected source; one-cycle events show as a rise
  function automatic logic srcHit(etc_src_t sel, etc_edge_t edgeSel,
                                  logic [NUM_SRC-1:0] now,
                                  logic [NUM_SRC-1:0] prev);
    logic rise;
    logic fall;
    rise = now[sel] & ~prev[sel];
    fall = ~now[sel] & prev[sel];
    if (sel == SRC_OFF) begin
      return 1'b0;
    end
    case (edgeSel)
      EDGE_UP: return rise;
      EDGE_DOWN: return fall;
      EDGE_EITHER: return rise | fall;
      default: return rise;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    // pins pass two flops before anything reads them
    next_st.pinSync1 = input_pins;
    next_st.pinSync2 = st.pinSync1;
    sig = '0;
    sig[SRC_CAPTURE_BEGIN] = events.capture_begin_event;
    sig[SRC_CAPTURE_FINISH] = events.capture_finish_event;
    sig[SRC_INTEG_BEGIN] = events.integration_begin_event;
    sig[SRC_INTEG_FINISH] = events.integration_finish_event;
    sig[SRC_IMAGE_BEGIN] = events.image_begin_event;
    sig[SRC_ACCEPTED_FRAME] = events.accepted_frame_trigger;
    sig[SRC_REJECTED] = events.rejected_trigger;
    sig[SRC_INPUT_PIN_A] = st.pinSync2[0];
    sig[SRC_INPUT_PIN_B] = st.pinSync2[1];
    sig[SRC_INPUT_PIN_C] = st.pinSync2[2];
    sig[SRC_FIRST_TIMER] = st.timerDone;
    sig[SRC_FIRST_COUNTER] = st.counterDone;
    next_st.prevSig = sig;

    // microsecond prescaler
    tick = (st.presc == PRESC_LAST);
    next_st.presc = tick ? PRESC_RESET : st.presc + 4'h1;

    next_st.timerDone = 1'b0;
    next_st.counterDone = 1'b0;

    // ---------------- timer ----------------
    // stored select only: a live edit while active must not launch
    if (st.tcfg.timer_trigger_select == SRC_OFF) begin
      timerLaunch = timer_clear_cmd;
    end else begin
      timerLaunch = srcHit(st.tcfg.timer_trigger_select,
                           st.tcfg.timer_edge_select,
                           sig, st.prevSig);
    end
    if (!timer_enable_mode) begin
      // settings only move in while disabled, so a run never sees them
      // change under it
      next_st.tcfg = timer_cfg;
      next_st.tmrState = TMR_IDLE;
      timerLaunch = 1'b0;
    end else begin
      if (timer_clear_cmd) begin
        next_st.elapsed = VAL_ZERO;
      end
      case (st.tmrState)
        TMR_IDLE: begin
          next_st.tmrState = TMR_TRIG_WAIT;
        end
        TMR_TRIG_WAIT, TMR_COMPLETED: begin
          if (timerLaunch) begin
            next_st.elapsed = VAL_ZERO;
            next_st.delayCnt = VAL_ZERO;
            next_st.tmrState = (st.tcfg.pulse_delay_us == VAL_ZERO) ?
                               TMR_ACTIVE : TMR_DELAYING;
          end
        end
        TMR_DELAYING: begin
          if (tick) begin
            next_st.delayCnt = st.delayCnt + VAL_ONE;
            if (st.delayCnt + VAL_ONE >= st.tcfg.pulse_delay_us) begin
              next_st.tmrState = TMR_ACTIVE;
            end
          end
        end
        TMR_ACTIVE: begin
          if (tick && !timer_clear_cmd) begin
            next_st.elapsed = st.elapsed + VAL_ONE;
            if (st.elapsed + VAL_ONE >= st.tcfg.pulse_length_us) begin
              next_st.tmrState = TMR_COMPLETED;
              next_st.timerDone = 1'b1;
            end
          end
        end
        default: next_st.tmrState = TMR_IDLE;
      endcase
    end
    // restarting the prescaler makes the pulse exactly whole microseconds
    if (timerLaunch && (st.tmrState == TMR_TRIG_WAIT ||
                        st.tmrState == TMR_COMPLETED)) begin
      next_st.presc = PRESC_RESET;
    end
    next_st.timerPulse = (next_st.tmrState == TMR_ACTIVE);

    // ---------------- counter ----------------
    cntHit = srcHit(count_event_select, count_edge_select, sig, st.prevSig);
    clrHit = (count_clear_select != SRC_FIRST_COUNTER) &&
             srcHit(count_clear_select, count_edge_select, sig, st.prevSig);
    cntLaunchHit = srcHit(count_launch_select, count_edge_select,
                          sig, st.prevSig);
    countInc = st.count + VAL_ONE;
    next_st.countEnPrev = count_enable_mode;
    if (!count_enable_mode) begin
      next_st.counting = 1'b0;
    end else if (count_launch_select == SRC_FIRST_COUNTER) begin
      if (!st.countEnPrev) begin
        next_st.counting = 1'b1;
        next_st.count = VAL_ZERO;
      end else if (count_clear_cmd) begin
        next_st.count = VAL_ZERO;
        next_st.counting = 1'b1;
      end else if (st.counting && cntHit) begin
        if (countInc == count_limit) begin
          next_st.counterDone = 1'b1;
          next_st.count = VAL_ZERO;
        end else begin
          next_st.count = countInc;
        end
      end
    end else begin
      if (count_clear_cmd) begin
        next_st.count = VAL_ZERO;
        next_st.counting = 1'b1;
      end else if (clrHit) begin
        next_st.count = VAL_ZERO;
        next_st.counting = 1'b0;
      end else if (!st.counting && cntLaunchHit) begin
        next_st.count = VAL_ZERO;
        next_st.counting = 1'b1;
      end else if (st.counting && cntHit) begin
        next_st.count = countInc;
        if (countInc == count_limit) begin
          next_st.counterDone = 1'b1;
          if (count_clear_select == SRC_FIRST_COUNTER) begin
            next_st.count = VAL_ZERO;
            next_st.counting = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign timer_pulse = st.timerPulse;
  assign first_timer_done = st.timerDone;
  assign elapsed_us = st.elapsed;
  assign timer_state_report = st.tmrState;
  assign count_limit_reached = st.counterDone;
  assign count_running = st.counting;
  assign current_count = st.count;

endmodule // etc_timer_counter

//--- tb/etc_partner.sv
`timescale 1ns/1ps
module etc_partner import etc_pkg::*; (
  // clock and request
  input wire logic core_clk,
  input wire logic go,
  input wire etc_src_t fire,
  // camera side
  output etc_events_t events = '0,
  output logic [NUM_PINS-1:0] input_pins = '0
);
  // events last one cycle; a pin fire is one transition, so two fires
  // give a rise then a fall
  always @(posedge core_clk) begin
    events <= '0;
    if (go && fire inside {[SRC_CAPTURE_BEGIN:SRC_REJECTED]})
      events <= etc_events_t'(7'h40 >> (fire - 1));
    if (go && fire inside {[SRC_INPUT_PIN_A:SRC_INPUT_PIN_C]})
      input_pins[fire - 8] <= ~input_pins[fire - 8];
  end
endmodule // etc_partner

//--- tb/etc_timer_counter_properties.sv
`timescale 1ns/1ps
module etc_timer_counter_properties import etc_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // controls
  input wire logic timer_enable_mode,
  input wire etc_timer_cfg_t timer_cfg,
  input wire logic timer_clear_cmd,
  input wire logic count_enable_mode,
  input wire etc_src_t count_launch_select,
  input wire logic count_clear_cmd,
  // status
  input wire logic timer_pulse,
  input wire logic first_timer_done,
  input wire logic [VAL_W-1:0] elapsed_us,
  input wire etc_tmr_state_t timer_state_report,
  input wire logic count_limit_reached,
  input wire logic count_running,
  input wire logic [VAL_W-1:0] current_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [VAL_W-1:0] hiLen;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) hiLen <= VAL_ZERO;
    else hiLen <= timer_pulse ? hiLen + VAL_ONE : VAL_ZERO;
  end
  a_pulse_is_active:
    assert property (timer_pulse == (timer_state_report == TMR_ACTIVE))
    else $error("pulse and state disagree");
  a_pulse_width:
    assert property ($fell(timer_pulse) |-> hiLen == 32'd10 *
      (timer_cfg.pulse_length_us == VAL_ZERO ? VAL_ONE :
      timer_cfg.pulse_length_us)) else $error("pulse width wrong");
  a_end_with_drop:
    assert property ($fell(timer_pulse) |-> first_timer_done &&
      timer_state_report == TMR_COMPLETED) else $error("end not flagged");
  a_end_single:
    assert property (first_timer_done |=> !first_timer_done)
    else $error("end pulse too long");
  a_no_start_off:
    assert property ($rose(timer_pulse) |-> $past(timer_enable_mode))
    else $error("launch while disabled");
  a_tclear_zero:
    assert property (timer_clear_cmd && timer_enable_mode |=>
      elapsed_us == VAL_ZERO) else $error("elapsed not cleared");
  a_elapsed_step:
    assert property ($changed(elapsed_us) |-> elapsed_us == VAL_ZERO ||
      elapsed_us == $past(elapsed_us) + VAL_ONE)
    else $error("elapsed jumped");
  a_cclear_restart:
    assert property (count_clear_cmd && count_enable_mode |=>
      current_count == VAL_ZERO && count_running)
    else $error("count clear failed");
  a_wrap_zero:
    assert property (count_limit_reached &&
      count_launch_select == SRC_FIRST_COUNTER |->
      current_count == VAL_ZERO && count_running)
    else $error("limit did not wrap");
endmodule // etc_timer_counter_properties
bind etc_timer_counter etc_timer_counter_properties u_props (.core_clk,
  .rst_n, .timer_enable_mode, .timer_cfg, .timer_clear_cmd,
  .count_enable_mode, .count_launch_select, .count_clear_cmd, .timer_pulse,
  .first_timer_done, .elapsed_us, .timer_state_report, .count_limit_reached,
  .count_running, .current_count);

//--- tb/event_timer_and_counter_group_bench.sv
`timescale 1ns/1ps
module event_timer_and_counter_group_bench import etc_pkg::*;;
  logic core_clk, rst_n, go, timer_enable_mode, timer_clear_cmd;
  logic count_enable_mode, count_clear_cmd, timer_pulse, first_timer_done;
  logic count_limit_reached, count_running;
  logic [NUM_PINS-1:0] input_pins;
  logic [VAL_W-1:0] count_limit, elapsed_us, current_count, e;
  etc_events_t events;
  etc_timer_cfg_t timer_cfg;
  etc_src_t fire, count_launch_select, count_clear_select;
  etc_src_t count_event_select;
  etc_edge_t count_edge_select;
  etc_tmr_state_t timer_state_report;
  int badCount = 0, compares = 0, w = 0, len;
  int ends = 0;
  int q[$];
  etc_partner u_etc_partner (.core_clk, .go, .fire, .events, .input_pins);
  etc_timer_counter u_etc_timer_counter (.core_clk, .rst_n, .events,
    .input_pins, .timer_enable_mode, .timer_cfg, .timer_clear_cmd,
    .count_enable_mode, .count_launch_select, .count_clear_select,
    .count_event_select, .count_edge_select, .count_limit, .count_clear_cmd,
    .timer_pulse, .first_timer_done, .elapsed_us, .timer_state_report,
    .count_limit_reached, .count_running, .current_count);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic completeRun();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [VAL_W-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic shoot(input etc_src_t s);
    fire = s;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(1);
  endtask
  task automatic cmd(input bit tmr);
    if (tmr) timer_clear_cmd = 1'b1;
    else count_clear_cmd = 1'b1;
    cyc(1);
    {timer_clear_cmd, count_clear_cmd} = 2'h0;
    cyc(1);
  endtask
  // no launch is ever awaited blind: a missing end is a mismatch
  task automatic settle();
    for (int i = 0; i < 400 && q.size() > 0; i++) cyc(1);
    if (q.size() > 0) begin
      badCount++;
      completeRun();
    end
    cyc(2);
  endtask
  // config only lands while disabled
  task automatic tset(input etc_src_t s, input etc_edge_t g, input int n,
                      input int d = 0);
    timer_enable_mode = 1'b0;
    cyc(2);
    timer_cfg = '{s, g, VAL_W'(d), VAL_W'(n)};
    cyc(1);
    timer_enable_mode = 1'b1;
    cyc(2);
  endtask
  // outputs read at the falling edge, where they are settled
  always @(negedge core_clk) begin
    if (count_limit_reached) ends++;
    if (timer_pulse) w++;
    if (first_timer_done) begin
      if (q.size() == 0) check(VAL_ONE, VAL_ZERO);
      else begin
        e = q.pop_front();
        check(w, e * 10);
        check(elapsed_us, e);
      end
      w = 0;
    end
  end
  initial begin
    {go, timer_enable_mode, timer_clear_cmd} = 3'h0;
    {count_enable_mode, count_clear_cmd} = 2'h0;
    timer_cfg = TIMER_CFG_RESET;
    fire = SRC_OFF;
    count_launch_select = SRC_OFF;
    count_clear_select = SRC_INTEG_BEGIN;
    count_event_select = SRC_CAPTURE_BEGIN;
    count_edge_select = EDGE_UP;
    count_limit = 32'h0000_0003;
    rst_n = 1'b0;
    void'($urandom(5));
    repeat (6) @(posedge core_clk);
    cyc(1);
    rst_n = 1'b1;
    for (int s = 1; s <= 10; s++) begin
      len = 1 + $urandom % 3;
      tset(etc_src_t'(s), s == 9 ? EDGE_DOWN : s == 10 ? EDGE_EITHER :
        EDGE_UP, len);
      shoot(s == 1 ? SRC_REJECTED : SRC_CAPTURE_BEGIN);
      check(timer_state_report, TMR_TRIG_WAIT);
      if (s != 9) q.push_back(len);
      shoot(etc_src_t'(s));
      settle();
      if (s >= 8) begin
        if (s != 8) q.push_back(len);
        shoot(etc_src_t'(s));
        settle();
      end
    end
    cmd(1'b1);
    check(elapsed_us, VAL_ZERO);
    timer_cfg.timer_trigger_select = SRC_REJECTED;
    shoot(SRC_REJECTED);
    check(timer_state_report, TMR_COMPLETED);
    timer_cfg.timer_trigger_select = SRC_OFF;
    cmd(1'b1);
    check(timer_state_report, TMR_COMPLETED);
    tset(SRC_OFF, EDGE_UP, 2, 1);
    q.push_back(2);
    cmd(1'b1);
    check(timer_state_report, TMR_DELAYING);
    settle();
    count_enable_mode = 1'b1;
    cmd(1'b0);
    repeat (2) shoot(SRC_CAPTURE_BEGIN);
    check(current_count, 32'h0000_0002);
    cmd(1'b0);
    check(current_count, VAL_ZERO);
    shoot(SRC_CAPTURE_BEGIN);
    shoot(SRC_INTEG_BEGIN);
    shoot(SRC_CAPTURE_BEGIN);
    check(current_count, VAL_ZERO);
    check(count_running, 1'b0);
    count_clear_select = SRC_FIRST_COUNTER;
    cmd(1'b0);
    repeat (3) shoot(SRC_CAPTURE_BEGIN);
    check(current_count, VAL_ZERO);
    check(count_running, 1'b0);
    count_enable_mode = 1'b0;
    cyc(1);
    count_launch_select = SRC_FIRST_COUNTER;
    count_clear_select = SRC_FIRST_COUNTER;
    tset(SRC_FIRST_COUNTER, EDGE_UP, 1);
    count_enable_mode = 1'b1;
    cyc(2);
    check(count_running, 1'b1);
    repeat (2) shoot(SRC_CAPTURE_BEGIN);
    cmd(1'b0);
    check(current_count, VAL_ZERO);
    q.push_back(1);
    repeat (3) shoot(SRC_CAPTURE_BEGIN);
    check(current_count, VAL_ZERO);
    settle();
    check(ends, 32'h0000_0002);
    completeRun();
  end
endmodule // event_timer_and_counter_group_bench
